// >>> hw/csfp_counter.sv
// Measurement counter with semi-period, period, pulse-width and position modes.
`timescale 1ns/1ns
`default_nettype none

// Operation
// - Buffered semi-period latches the count on every measure-input edge after the first.
// - Latched values leave in capture order over the stream port.
// - After arming, counting starts only at the first active measure edge, except in position modes, which count from arming.
// - The partial interval before the first measure edge is never stored.
// - No count-input edge between measure edges stores zero.
// - Count input can select the 80 MHz fast internal timebase.
// - Period mode counts edges between two like measure edges.
// - Single pulse-width capture counts while measure input is active.
// - Measure input can come from the programmable function terminal.
// - The pulse generator makes one pulse of N periods of its own count input.
// - That pulse can feed this counter's measure input.
// - Position decodes quadrature at one, two, four edges or two-pulse.
// - Position offers on-demand readout and sample-clock buffered readout.
// - Position counting starts only after explicit arming.
// - A semi-period spans any two consecutive measure edges.
// - Single pulse-width stores at trailing edge, then ignores inputs.
module csfp_counter
  import csfp_pkg::*;
#(
  parameter int COUNT_W = CSFP_COUNT_W
) (
  input wire logic sys_clk,                              // System clock, 20 MHz
  input wire logic rst,                                  // Synchronous reset, active high
  input wire csfp_cfg_s cfg,                             // Mode and routing configuration
  input wire logic arm,                                  // Arm pulse
  input wire logic disarm,                               // Disarm pulse
  input wire logic read_req,                             // On-demand position read pulse
  input wire logic overrun_clr,                          // Clears the overrun flag
  input wire logic pulse_arm,                            // Starts the pulse generator
  input wire logic [COUNT_W-1:0] pulse_len_n,            // Pulse width in periods
  input wire logic src_pin,                              // External count input
  input wire logic gate_pin,                             // External measure input
  input wire logic programmable_function_terminal,       // Alternate measure input
  input wire logic pulse_src_pin,                        // Pulse generator count input
  input wire logic enc_a_pin,                            // Encoder channel A
  input wire logic enc_b_pin,                            // Encoder channel B
  input wire logic sample_pin,                           // Position sample clock
  input wire logic strm_ready,                           // Stream sink accepts
  output logic strm_valid,                               // Stream word valid
  output logic [COUNT_W-1:0] strm_data,                  // Stream word
  output logic overrun,                                  // Sticky overrun flag
  output logic done,                                     // Single measurement finished
  output logic pulse_out                                 // Pulse generator output
);

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  function automatic logic [CSFP_STEP_W-1:0] src_step(input logic fast, input logic rise_act,
                                                     input logic cur, input logic prv);
    logic hit;
    hit = rise_act ? (cur & ~prv) : (~cur & prv);
    if (fast) begin
      src_step = CSFP_FAST_TB_PER_CLK;
    end else begin
      src_step = hit ? CSFP_ONE_STEP : CSFP_NO_STEP;
    end
  endfunction

  function automatic logic signed [2:0] enc_delta(input csfp_decode_e dec, input logic a, input logic b,
                                                 input logic ar, input logic af, input logic br,
                                                 input logic bf);
    logic signed [2:0] d;
    d = 3'sh0;
    case (dec)
      CSFP_DEC_SINGLE_EDGE: begin
        if (ar & ~b) d = 3'sh1;
        else if (af & ~b) d = -3'sh1;
      end
      CSFP_DEC_DOUBLE_EDGE: begin
        if (ar) d = b ? -3'sh1 : 3'sh1;
        else if (af) d = b ? 3'sh1 : -3'sh1;
      end
      CSFP_DEC_QUAD_EDGE: begin
        if (ar) d = d + (b ? -3'sh1 : 3'sh1);
        if (af) d = d + (b ? 3'sh1 : -3'sh1);
        if (br) d = d + (a ? 3'sh1 : -3'sh1);
        if (bf) d = d + (a ? -3'sh1 : 3'sh1);
      end
      CSFP_DEC_TWO_PULSE: begin
        d = (ar ? 3'sh1 : 3'sh0) - (br ? 3'sh1 : 3'sh0);
      end
      default: d = 3'sh0;
    endcase
    enc_delta = d;
  endfunction

  // ---------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------
  logic [CSFP_NUM_PINS-1:0] meta_ff;
  logic [CSFP_NUM_PINS-1:0] sync_ff;
  logic [CSFP_NUM_PINS-1:0] prev_ff;
  logic [CSFP_NUM_PINS-1:0] pins;

  assign pins = {sample_pin, enc_b_pin, enc_a_pin, pulse_src_pin, programmable_function_terminal,
                 gate_pin, src_pin};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_ff <= CSFP_PINS_RESET;
      sync_ff <= CSFP_PINS_RESET;
      prev_ff <= CSFP_PINS_RESET;
    end else begin
      meta_ff <= pins;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // ---------------------------------------------------------------------
  // Count input, pulse generator and measure input routing
  // ---------------------------------------------------------------------
  logic [CSFP_STEP_W-1:0] step;
  logic [CSFP_STEP_W-1:0] pulse_step;
  logic gate_cur;
  logic gate_prv_ff;
  logic g_rise;
  logic g_fall;
  logic g_lead;
  logic g_trail;
  logic g_any;

  assign step = src_step(cfg.src_fast, cfg.src_rise, sync_ff[CSFP_PIN_SRC], prev_ff[CSFP_PIN_SRC]);
  assign pulse_step = src_step(cfg.pulse_src_fast, cfg.src_rise, sync_ff[CSFP_PIN_PULSE_SRC],
                               prev_ff[CSFP_PIN_PULSE_SRC]);

  csfp_pulse_gen #(
    .COUNT_W(COUNT_W)
  ) u_pulse_gen (
    .sys_clk(sys_clk),
    .rst(rst),
    .arm(pulse_arm),
    .len_n(pulse_len_n),
    .step(pulse_step),
    .pulse(pulse_out)
  );

  // The internal pulse is already on sys_clk, so it is routed without a synchroniser.
  always_comb begin
    case (cfg.gate_sel)
      CSFP_GATE_PIN: gate_cur = sync_ff[CSFP_PIN_GATE];
      CSFP_GATE_TERM: gate_cur = sync_ff[CSFP_PIN_TERM];
      CSFP_GATE_PULSE: gate_cur = pulse_out;
      CSFP_GATE_SAMPLE: gate_cur = sync_ff[CSFP_PIN_SAMPLE];
      default: gate_cur = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gate_prv_ff <= 1'b0;
    end else begin
      gate_prv_ff <= gate_cur;
    end
  end

  assign g_rise = gate_cur & ~gate_prv_ff;
  assign g_fall = ~gate_cur & gate_prv_ff;
  assign g_lead = cfg.gate_rise ? g_rise : g_fall;
  assign g_trail = cfg.gate_rise ? g_fall : g_rise;
  assign g_any = g_rise | g_fall;

  // ---------------------------------------------------------------------
  // Measurement state machine
  // ---------------------------------------------------------------------
  csfp_state_e state_ff;
  csfp_state_e nxt_state;
  logic [COUNT_W-1:0] cnt_ff;
  logic [COUNT_W-1:0] nxt_cnt;
  logic [COUNT_W-1:0] latch_val;
  logic latch;
  logic is_pos;
  logic is_single;
  logic start_edge;
  logic stop_edge;
  logic signed [2:0] delta;

  assign is_pos = (cfg.mode == CSFP_MODE_POS_SINGLE) || (cfg.mode == CSFP_MODE_POS_BUF);
  assign is_single = (cfg.mode == CSFP_MODE_PERIOD_SINGLE) || (cfg.mode == CSFP_MODE_PW_SINGLE);
  assign delta = enc_delta(cfg.decode, sync_ff[CSFP_PIN_ENC_A], sync_ff[CSFP_PIN_ENC_B],
                           sync_ff[CSFP_PIN_ENC_A] & ~prev_ff[CSFP_PIN_ENC_A],
                           ~sync_ff[CSFP_PIN_ENC_A] & prev_ff[CSFP_PIN_ENC_A],
                           sync_ff[CSFP_PIN_ENC_B] & ~prev_ff[CSFP_PIN_ENC_B],
                           ~sync_ff[CSFP_PIN_ENC_B] & prev_ff[CSFP_PIN_ENC_B]);

  always_comb begin
    case (cfg.mode)
      CSFP_MODE_SEMI_BUF: begin
        start_edge = g_any;
        stop_edge = g_any;
      end
      CSFP_MODE_PERIOD_SINGLE, CSFP_MODE_PERIOD_BUF: begin
        start_edge = g_lead;
        stop_edge = g_lead;
      end
      CSFP_MODE_PW_SINGLE: begin
        start_edge = g_lead;
        stop_edge = g_trail;
      end
      default: begin
        start_edge = 1'b0;
        stop_edge = 1'b0;
      end
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    latch = 1'b0;
    latch_val = cnt_ff;
    case (state_ff)
      CSFP_ST_IDLE: begin
        nxt_cnt = CSFP_COUNT_ZERO;
        if (arm) begin
          nxt_state = is_pos ? CSFP_ST_COUNT : CSFP_ST_WAIT;
        end
      end
      CSFP_ST_WAIT: begin
        nxt_cnt = CSFP_COUNT_ZERO;
        if (start_edge) begin
          nxt_state = CSFP_ST_COUNT;
        end
      end
      CSFP_ST_COUNT: begin
        if (is_pos) begin
          nxt_cnt = cnt_ff + COUNT_W'(delta);
          latch = (cfg.mode == CSFP_MODE_POS_SINGLE) ? read_req : g_lead;
        end else if (stop_edge) begin
          latch = 1'b1;
          nxt_cnt = COUNT_W'(step);
          if (is_single) begin
            nxt_state = CSFP_ST_DONE;
          end
        end else begin
          nxt_cnt = cnt_ff + COUNT_W'(step);
        end
      end
      CSFP_ST_DONE: begin
        nxt_cnt = cnt_ff;
      end
      default: begin
        nxt_state = CSFP_ST_IDLE;
        nxt_cnt = CSFP_COUNT_ZERO;
      end
    endcase
    if (disarm) begin
      nxt_state = CSFP_ST_IDLE;
      nxt_cnt = CSFP_COUNT_ZERO;
      latch = 1'b0;
    end else if (arm && state_ff != CSFP_ST_IDLE) begin
      nxt_state = is_pos ? CSFP_ST_COUNT : CSFP_ST_WAIT;
      nxt_cnt = CSFP_COUNT_ZERO;
      latch = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_ff <= CSFP_ST_IDLE;
      cnt_ff <= CSFP_COUNT_ZERO;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  // ---------------------------------------------------------------------
  // Completion flag
  // ---------------------------------------------------------------------
  logic done_ff;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= (nxt_state == CSFP_ST_DONE);
    end
  end

  // ---------------------------------------------------------------------
  // Save register and stream output
  // ---------------------------------------------------------------------
  logic strm_valid_ff;
  logic [COUNT_W-1:0] strm_data_ff;
  logic overrun_ff;

  // A value that finds the save register still full is dropped, so stored values never reorder.
  // in-order stream hand-off
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      strm_valid_ff <= 1'b0;
      strm_data_ff <= CSFP_COUNT_ZERO;
    end else if (latch && (!strm_valid_ff || strm_ready)) begin
      strm_valid_ff <= 1'b1;
      strm_data_ff <= latch_val;
    end else if (strm_ready) begin
      strm_valid_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      overrun_ff <= 1'b0;
    end else if (latch && strm_valid_ff && !strm_ready) begin
      overrun_ff <= 1'b1;
    end else if (overrun_clr) begin
      overrun_ff <= 1'b0;
    end
  end

  assign strm_valid = strm_valid_ff;
  assign strm_data = strm_data_ff;
  assign overrun = overrun_ff;
  assign done = done_ff;

endmodule

`default_nettype wire

// >>> hw/csfp_pkg.sv
// Shared constants, types and carriers for the counter measurement block.
package csfp_pkg;

  // ---------------------------------------------------------------------
  // Widths and timebase
  // ---------------------------------------------------------------------
  localparam int CSFP_COUNT_W = 32;
  localparam int CSFP_STEP_W = 4;
  localparam int CSFP_FAST_TB_MHZ = 80;
  localparam int CSFP_SYS_CLK_MHZ = 20;
  // The fast timebase is faster than sys_clk, so it is counted as a fixed number of ticks per cycle.
  localparam logic [CSFP_STEP_W-1:0] CSFP_FAST_TB_PER_CLK = CSFP_STEP_W'(CSFP_FAST_TB_MHZ / CSFP_SYS_CLK_MHZ);
  localparam logic [CSFP_STEP_W-1:0] CSFP_ONE_STEP = 4'h1;
  localparam logic [CSFP_STEP_W-1:0] CSFP_NO_STEP = 4'h0;

  // ---------------------------------------------------------------------
  // Pin positions in the synchroniser vector
  // ---------------------------------------------------------------------
  localparam int CSFP_NUM_PINS = 7;
  localparam int CSFP_PIN_SRC = 0;
  localparam int CSFP_PIN_GATE = 1;
  localparam int CSFP_PIN_TERM = 2;
  localparam int CSFP_PIN_PULSE_SRC = 3;
  localparam int CSFP_PIN_ENC_A = 4;
  localparam int CSFP_PIN_ENC_B = 5;
  localparam int CSFP_PIN_SAMPLE = 6;
  localparam logic [CSFP_NUM_PINS-1:0] CSFP_PINS_RESET = 7'h00;

  // ---------------------------------------------------------------------
  // Modes and selections
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    CSFP_MODE_SEMI_BUF = 3'h0,
    CSFP_MODE_PERIOD_SINGLE = 3'h1,
    CSFP_MODE_PERIOD_BUF = 3'h2,
    CSFP_MODE_PW_SINGLE = 3'h3,
    CSFP_MODE_POS_SINGLE = 3'h4,
    CSFP_MODE_POS_BUF = 3'h5
  } csfp_mode_e;

  typedef enum logic [1:0] {
    CSFP_GATE_PIN = 2'h0,
    CSFP_GATE_TERM = 2'h1,
    CSFP_GATE_PULSE = 2'h2,
    CSFP_GATE_SAMPLE = 2'h3
  } csfp_gate_sel_e;

  typedef enum logic [1:0] {
    CSFP_DEC_SINGLE_EDGE = 2'h0,
    CSFP_DEC_DOUBLE_EDGE = 2'h1,
    CSFP_DEC_QUAD_EDGE = 2'h2,
    CSFP_DEC_TWO_PULSE = 2'h3
  } csfp_decode_e;

  typedef enum logic [3:0] {
    CSFP_ST_IDLE = 4'h1,
    CSFP_ST_WAIT = 4'h2,
    CSFP_ST_COUNT = 4'h4,
    CSFP_ST_DONE = 4'h8
  } csfp_state_e;

  typedef struct packed {
    csfp_mode_e mode;
    csfp_gate_sel_e gate_sel;
    logic src_fast;
    logic src_rise;
    logic gate_rise;
    csfp_decode_e decode;
    logic pulse_src_fast;
  } csfp_cfg_s;

  localparam logic [CSFP_COUNT_W-1:0] CSFP_COUNT_ZERO = 32'h0000_0000;

endpackage

// >>> hw/csfp_pulse_gen.sv
// Single pulse generator whose width is a programmed number of source periods.
`timescale 1ns/1ns
`default_nettype none

module csfp_pulse_gen
  import csfp_pkg::*;
#(
  parameter int COUNT_W = CSFP_COUNT_W
) (
  input wire logic sys_clk,                  // System clock
  input wire logic rst,                      // Synchronous reset, active high
  input wire logic arm,                      // Start one pulse
  input wire logic [COUNT_W-1:0] len_n,      // Pulse width in source periods
  input wire logic [CSFP_STEP_W-1:0] step,   // Source periods seen this cycle
  output logic pulse                         // Pulse output
);

  logic pulse_ff;
  logic [COUNT_W:0] acc_ff;
  logic [COUNT_W:0] nxt_acc;

  assign nxt_acc = acc_ff + (COUNT_W + 1)'(step);
  assign pulse = pulse_ff;

  // ---------------------------------------------------------------------
  // Pulse timing
  // ---------------------------------------------------------------------
  // N period pulse
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pulse_ff <= 1'b0;
      acc_ff <= '0;
    end else if (arm) begin
      pulse_ff <= (len_n != '0);
      acc_ff <= '0;
    end else if (pulse_ff) begin
      acc_ff <= nxt_acc;
      if (nxt_acc >= {1'b0, len_n}) begin
        pulse_ff <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// >>> testbench/counter_semiperiod_freq_position_bench.sv
// Self-checking bench for the measurement counter.
`timescale 1ns/1ns
`default_nettype none

module counter_semiperiod_freq_position_bench;
  import csfp_pkg::*;

  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  csfp_cfg_s cfg;
  logic [3:0] ctl;
  logic overrun_clr;
  logic [CSFP_COUNT_W-1:0] pulse_len_n;
  logic [CSFP_NUM_PINS-1:0] pins;
  logic src_on, stall, src_pin, strm_ready, strm_valid, overrun, done, pulse_out;
  logic [1:0] phase;
  logic [CSFP_COUNT_W-1:0] strm_data;
  logic [CSFP_COUNT_W-1:0] q[$];
  logic [31:0] semi_exp[4] = '{32'h2, 32'h1, 32'h3, 32'h0};
  logic [31:0] pos_exp[4] = '{32'h2, 32'h4, 32'h8, 32'h0};
  int sgl_k[5] = '{0, 2, 1, 1, 1};
  int error_cnt = 0;
  int samples_checked = 0;

  always #25 sys_clk = ~sys_clk;

  csfp_counter DUT (.sys_clk(sys_clk), .rst(rst), .cfg(cfg), .arm(ctl[0]), .disarm(ctl[1]), .read_req(ctl[2]),
    .overrun_clr(overrun_clr), .pulse_arm(ctl[3]), .pulse_len_n(pulse_len_n), .src_pin(src_pin),
    .gate_pin(pins[CSFP_PIN_GATE]), .programmable_function_terminal(pins[CSFP_PIN_TERM]),
    .pulse_src_pin(pins[CSFP_PIN_PULSE_SRC]), .enc_a_pin(pins[CSFP_PIN_ENC_A]), .enc_b_pin(pins[CSFP_PIN_ENC_B]),
    .sample_pin(pins[CSFP_PIN_SAMPLE]), .strm_ready(strm_ready), .strm_valid(strm_valid),
    .strm_data(strm_data), .overrun(overrun), .done(done), .pulse_out(pulse_out));

  csfp_far_side far (.sys_clk(sys_clk), .src_on(src_on), .stall(stall), .src_pin(src_pin),
    .strm_ready(strm_ready), .phase(phase));

  always @(posedge sys_clk) begin
    if (strm_valid === 1'b1 && strm_ready === 1'b1) begin
      q.push_back(strm_data);
    end
  end

  // ---------------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask

  task automatic pq(input logic [31:0] exp);
    logic [31:0] got;
    got = 'x;
    for (int i = 0; i < 60 && q.size() == 0; i++) @(negedge sys_clk);
    if (q.size() > 0) got = q.pop_front();
    chk(got, exp);
  endtask

  task automatic go(input logic [3:0] v);
    @(negedge sys_clk);
    ctl = v;
    @(negedge sys_clk);
    ctl = 4'h0;
  endtask

  // Gate changes land at phase 0, well clear of source rises.
  task automatic align;
    do @(negedge sys_clk); while (phase !== 2'h0);
  endtask

  task automatic tg(input int p, input int k);
    repeat (4 * k) @(negedge sys_clk);
    pins[p] = ~pins[p];
  endtask

  // One forward quadrature cycle per count, then time for the synchroniser.
  task automatic spin(input int n);
    for (int i = 0; i < 4 * n; i++) tg(i % 2 == 0 ? CSFP_PIN_ENC_A : CSFP_PIN_ENC_B, 1);
    repeat (4) @(negedge sys_clk);
  endtask

  task automatic test_done;
    $display("checked %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    test_done;
  end

  // ---------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------
  initial begin
    cfg = '0;
    ctl = 4'h0;
    overrun_clr = 1'b0;
    pulse_len_n = '0;
    pins = CSFP_PINS_RESET;
    src_on = 1'b1;
    stall = 1'b0;
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk(32'({strm_valid, overrun, done, pulse_out}), 32'h0);
    cfg.mode = CSFP_MODE_SEMI_BUF;
    cfg.src_rise = 1'b1;
    cfg.gate_rise = 1'b1;
    go(4'h1);
    align;
    tg(CSFP_PIN_GATE, 0);
    tg(CSFP_PIN_GATE, 2);
    tg(CSFP_PIN_GATE, 1);
    tg(CSFP_PIN_GATE, 3);
    src_on = 1'b0;
    tg(CSFP_PIN_GATE, 2);
    src_on = 1'b1;
    stall = 1'b1;
    tg(CSFP_PIN_GATE, 1);
    tg(CSFP_PIN_GATE, 1);
    repeat (8) @(negedge sys_clk);
    chk(32'(overrun), 32'h1);
    stall = 1'b0;
    foreach (semi_exp[i]) pq(semi_exp[i]);
    repeat (4) @(negedge sys_clk);
    chk(32'(q.size()), 32'h0);
    overrun_clr = 1'b1;
    @(negedge sys_clk);
    overrun_clr = 1'b0;
    @(negedge sys_clk);
    chk(32'(overrun), 32'h0);
    go(4'h2);
    pins[CSFP_PIN_GATE] = 1'b0;
    cfg.mode = CSFP_MODE_PERIOD_BUF;
    cfg.src_fast = 1'b1;
    go(4'h1);
    for (int i = 0; i < 5; i++) tg(CSFP_PIN_GATE, 2);
    repeat (10) @(negedge sys_clk);
    chk(32'(q.size()), 32'h2);
    chk(q[1], 32'h40);
    q.delete();
    go(4'h2);
    cfg.src_fast = 1'b0;
    for (int r = 0; r < 2; r++) begin
      cfg.mode = r ? CSFP_MODE_PW_SINGLE : CSFP_MODE_PERIOD_SINGLE;
      cfg.gate_sel = r ? CSFP_GATE_PIN : CSFP_GATE_TERM;
      // The gate pin idles high on the second pass, so that pass measures a low pulse.
      cfg.gate_rise = (r == 0);
      go(4'h1);
      align;
      foreach (sgl_k[i]) tg(r ? CSFP_PIN_GATE : CSFP_PIN_TERM, sgl_k[i]);
      chk(32'(done), 32'h1);
      pq(r ? 32'h2 : 32'h3);
      // Let the last gate edge pass the synchroniser before looking for a stray word.
      repeat (4) @(negedge sys_clk);
      chk(32'(q.size()), 32'h0);
    end
    cfg.gate_rise = 1'b1;
    cfg.gate_sel = CSFP_GATE_PULSE;
    cfg.src_fast = 1'b1;
    cfg.pulse_src_fast = 1'b1;
    pulse_len_n = 32'h28;
    go(4'h1);
    go(4'h8);
    repeat (30) @(negedge sys_clk);
    chk(32'(q.size() == 1 && q[0] >= 32'h24 && q[0] <= 32'h2C), 32'h1);
    q.delete();
    cfg.mode = CSFP_MODE_POS_SINGLE;
    for (int d = 0; d < 4; d++) begin
      go(4'h2);
      cfg.decode = csfp_decode_e'(d);
      spin(1);
      go(4'h1);
      spin(2);
      go(4'h4);
      pq(pos_exp[d]);
    end
    go(4'h2);
    cfg.mode = CSFP_MODE_POS_BUF;
    cfg.gate_sel = CSFP_GATE_SAMPLE;
    cfg.decode = CSFP_DEC_QUAD_EDGE;
    go(4'h1);
    for (int s = 1; s < 3; s++) begin
      spin(1);
      tg(CSFP_PIN_SAMPLE, 0);
      tg(CSFP_PIN_SAMPLE, 2);
      pq(32'(4 * s));
    end
    test_done;
  end
endmodule

`default_nettype wire

// >>> testbench/csfp_counter_assertions.sv
// Port-level checker for the measurement counter, bound to its top module.
`timescale 1ns/1ns
`default_nettype none

module csfp_counter_checker
  import csfp_pkg::*;
#(
  parameter int COUNT_W = CSFP_COUNT_W
) (
  input wire logic sys_clk,                    // Clock
  input wire logic rst,                        // Reset
  input wire csfp_cfg_s cfg,                   // Configuration
  input wire logic arm,                        // Arm
  input wire logic disarm,                     // Disarm
  input wire logic read_req,                   // Position read
  input wire logic overrun_clr,                // Overrun clear
  input wire logic pulse_arm,                  // Pulse start
  input wire logic [COUNT_W-1:0] pulse_len_n,  // Pulse width
  input wire logic strm_ready,                 // Sink ready
  input wire logic strm_valid,                 // Word valid
  input wire logic [COUNT_W-1:0] strm_data,    // Word
  input wire logic overrun,                    // Overrun flag
  input wire logic done,                       // Done flag
  input wire logic pulse_out                   // Pulse output
);
  // Armed state is rebuilt here because the ports do not show it.
  logic armed_ff;

  always_ff @(posedge sys_clk) begin
    if (rst || disarm) begin
      armed_ff <= 1'b0;
    end else if (arm) begin
      armed_ff <= 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_OVR_CAUSE: assert property ($rose(overrun) |-> $past(strm_valid && !strm_ready))
    else $error("overrun set without a refused word");
  AST_OVR_STICKY: assert property (overrun && !overrun_clr |=> overrun)
    else $error("overrun dropped without clear");
  AST_WORD_HOLD: assert property (strm_valid && !strm_ready && !arm && !disarm |=> strm_valid && $stable(strm_data))
    else $error("stream word changed before acceptance");
  AST_PULSE_START: assert property (pulse_arm && pulse_len_n != '0 |=> pulse_out)
    else $error("pulse did not start after pulse arm");
  AST_PULSE_CAUSE: assert property ($rose(pulse_out) |-> $past(pulse_arm))
    else $error("pulse started without pulse arm");
  AST_DONE_CLR: assert property (arm || disarm |=> !done)
    else $error("done kept after arm or disarm");
  AST_DONE_KEEP: assert property (done && !arm && !disarm |=> done && !$rose(strm_valid))
    else $error("finished single measurement reacted to inputs");
  AST_DONE_WORD: assert property ($rose(done) |-> strm_valid)
    else $error("done without stored word");
  AST_READ: assert property (armed_ff && cfg.mode == CSFP_MODE_POS_SINGLE && read_req |=> strm_valid)
    else $error("on-demand read gave no word");
  AST_ARMED_ONLY: assert property ($rose(strm_valid) |-> armed_ff || $past(armed_ff))
    else $error("word produced while not armed");

  cover property ($rose(overrun));
  cover property ($rose(done));
  cover property (strm_valid && strm_ready);
  cover property ($fell(pulse_out));
endmodule

bind csfp_counter csfp_counter_checker #(.COUNT_W(COUNT_W)) u_chk (
  .sys_clk(sys_clk), .rst(rst), .cfg(cfg), .arm(arm), .disarm(disarm), .read_req(read_req),
  .overrun_clr(overrun_clr), .pulse_arm(pulse_arm), .pulse_len_n(pulse_len_n), .strm_ready(strm_ready),
  .strm_valid(strm_valid), .strm_data(strm_data), .overrun(overrun), .done(done), .pulse_out(pulse_out)
);

`default_nettype wire

// >>> testbench/csfp_far_side.sv
// Far-side model: external count source and host stream sink.
`timescale 1ns/1ns
`default_nettype none

module csfp_far_side (
  input wire logic sys_clk,   // System clock
  input wire logic src_on,    // Run the count source
  input wire logic stall,     // Hold off the stream
  output logic src_pin,       // External count input
  output logic strm_ready,    // Sink accepts
  output logic [1:0] phase    // Source phase
);
  logic [1:0] ph_ff = 2'h0;
  logic src_ff = 1'b0;
  logic rdy_ff = 1'b1;

  assign phase = ph_ff;
  assign src_pin = src_ff;
  assign strm_ready = rdy_ff;

  // one pulse per interval
  // Source rises two cycles away from any phase-0 gate change, so counts never straddle.
  always @(posedge sys_clk) begin
    ph_ff <= ph_ff + 2'h1;
    src_ff <= src_on & (ph_ff == 2'h1 || ph_ff == 2'h2);
  end

  always @(posedge sys_clk) begin
    rdy_ff <= ~stall;
  end
endmodule

`default_nettype wire
